// ### pio_pkg.sv
/*
  Package for the parallel port block: port counts, widths, line positions on
  the fixed input port, the internal bus-clock divider and the bus carrier.
  Assumes a single system clock domain with an asynchronous active-high reset.
*/
package pio_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int PIO_PORT_W    = 8;
  localparam int PIO_NUM_PORTS = 3;
  localparam int PIO_FIX_W     = 8;

  // ****************************************************************
  // Fixed input port line positions
  // ****************************************************************
  localparam int PIO_LN_RXD  = 0;
  localparam int PIO_LN_TXD  = 1;
  localparam int PIO_LN_MISO = 2;
  localparam int PIO_LN_MOSI = 3;
  localparam int PIO_LN_SCK  = 4;
  localparam int PIO_LN_SS   = 5;
  localparam int PIO_LN_NONE = 6;

  localparam logic [PIO_FIX_W-1:0] PIO_SERIAL_MASK = 8'h03;
  localparam logic [PIO_FIX_W-1:0] PIO_SPI_MASK    = 8'h3c;
  localparam logic [PIO_FIX_W-1:0] PIO_FIX_PRESENT = 8'hbf;

  // ****************************************************************
  // Port select codes
  // ****************************************************************
  localparam logic [1:0] PIO_SEL_P1  = 2'h0;
  localparam logic [1:0] PIO_SEL_P2  = 2'h1;
  localparam logic [1:0] PIO_SEL_P3  = 2'h2;
  localparam logic [1:0] PIO_SEL_FIX = 2'h3;

  // Bus clock is the oscillator divided by this ratio
  localparam int PIO_BUS_DIV = 2;

  // ****************************************************************
  // Carrier
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       dir;
    logic [1:0] sel;
    logic [7:0] wdata;
  } pio_req_t;

endpackage

// ### pio_port.sv
/*
  One bidirectional 8-bit port: direction register, output latch, pin drive
  and read-back. Assumes pin inputs arrive already synchronised and that
  strobes are qualified by the bus-clock phase in the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module pio_port #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Write strobes
  input  wire logic         dat_we_i,
  input  wire logic         dir_we_i,
  input  wire logic [W-1:0] wdata_i,
  // Pin side
  input  wire logic [W-1:0] pin_sync_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe_o,
  // Read side
  output logic      [W-1:0] rdata_o,
  output logic      [W-1:0] dir_o
);

  logic [W-1:0] dir;
  logic [W-1:0] latch;

  // ****************************************************************
  // Direction register
  // ****************************************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dir <= '0;                                   // [RULE_02]
    end else if (ce_i && dir_we_i) begin
      dir <= wdata_i;                              // [RULE_01] [RULE_17]
    end
  end

  // ****************************************************************
  // Output latch
  // ****************************************************************
  // No reset on purpose: contents stay as they were across a reset
  always_ff @(posedge mclk_i) begin
    if (ce_i && dat_we_i) begin
      latch <= wdata_i;                            // [RULE_03] [RULE_04] [RULE_17]
    end
  end

  // Input bits stay undriven; output bits carry the latch
  assign pin_oe_o = dir;                           // [RULE_05] [RULE_06]
  assign pin_o    = latch & dir;                   // [RULE_06]
  assign dir_o    = dir;
  assign rdata_o  = (latch & dir) | (pin_sync_i & ~dir);  // [RULE_07] [RULE_08]

endmodule
`default_nettype wire

// ### pio_top.sv
/*
  Parallel I/O: three bidirectional 8-bit ports and a seven-line fixed
  input port shared with the async serial unit and the SPI unit.
  Assumes mclk_i is the oscillator clock; accesses are sequenced on the
  internal bus clock, an enable at half that rate. Requests are held by the
  processor until the bus-clock phase that completes them.
*/
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// RULE_01: Direction bit one means output, zero input.
// RULE_02: Reset clears all direction registers to input.
// RULE_03: Reset leaves output latches unchanged.
// RULE_04: Every port write loads all eight latch bits.
// RULE_05: Input-direction write only updates the latch.
// RULE_06: Output-direction write drives latched value onto pin.
// RULE_07: Input-direction read returns pin level.
// RULE_08: Output-direction read returns latch, not pin.
// RULE_09: Three independent 8-bit ports, own latch, direction.
// RULE_10: Fixed port reads pin level when function disabled.
// RULE_11: Enabled serial or SPI lines read zero.
// RULE_12: After reset serial drivers off, all lines valid.
// RULE_13: Serial uses line 1 transmit, line 0 receive.
// RULE_14: SPI uses lines 5..2: SS, SCK, MOSI, MISO.
// RULE_15: Bus clock runs at half oscillator rate.
// RULE_16: Software writes latch before setting output direction.
// RULE_17: Writes reach the pins at completing bus edge.
//
module pio_top
  import pio_pkg::*;
#(
  parameter int PORT_W = pio_pkg::PIO_PORT_W,
  parameter int NPORT  = pio_pkg::PIO_NUM_PORTS
) (
  // Clock, reset, enable
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // Processor side
  input  wire pio_pkg::pio_req_t       req_i,
  output logic      [PORT_W-1:0]       rdata_o,
  output logic                         rvalid_o,
  output logic                         bus_phase_o,
  // Serial function enables
  input  wire logic                    serial_en_i,
  input  wire logic                    spi_en_i,
  // Bidirectional port pins
  input  wire logic [NPORT*PORT_W-1:0] bidir_pins_i,
  output logic      [NPORT*PORT_W-1:0] bidir_pins_o,
  output logic      [NPORT*PORT_W-1:0] bidir_pins_oe_o,
  // Fixed input port pins
  input  wire logic [PORT_W-1:0]       fixed_input_port_pins_i,
  // Direction readback
  output logic      [NPORT*PORT_W-1:0] dir_o
);
  import pio_pkg::*;

  // ****************************************************************
  // Internal bus clock enable
  // ****************************************************************
  // One bus cycle per two oscillator cycles; only the second phase acts
  logic [1:0] div_cnt;
  logic       bus_tick;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt <= 2'h0;
    end else if (ce_i) begin
      if (div_cnt == 2'(PIO_BUS_DIV - 1)) begin
        div_cnt <= 2'h0;                               // [RULE_15]
      end else begin
        div_cnt <= div_cnt + 2'h1;
      end
    end
  end
  assign bus_tick    = (div_cnt == 2'(PIO_BUS_DIV - 1));  // [RULE_15]
  assign bus_phase_o = bus_tick;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [NPORT*PORT_W-1:0] bidir_s1;
  logic [NPORT*PORT_W-1:0] bidir_s2;
  logic [PORT_W-1:0]       fix_s1;
  logic [PORT_W-1:0]       fix_s2;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bidir_s1 <= '0;
      bidir_s2 <= '0;
      fix_s1   <= '0;
      fix_s2   <= '0;
    end else if (ce_i) begin
      bidir_s1 <= bidir_pins_i;
      bidir_s2 <= bidir_s1;
      fix_s1   <= fixed_input_port_pins_i;
      fix_s2   <= fix_s1;
    end
  end

  // ****************************************************************
  // Bidirectional ports
  // ****************************************************************
  logic [NPORT*PORT_W-1:0] port_rd;

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic hit;
    assign hit = bus_tick && req_i.wr && (req_i.sel == 2'(p));
    pio_port #(.W(PORT_W)) u_port (                  // [RULE_09]
      .mclk_i     (mclk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .dat_we_i   (hit && !req_i.dir),
      .dir_we_i   (hit && req_i.dir),
      .wdata_i    (req_i.wdata[PORT_W-1:0]),
      .pin_sync_i (bidir_s2[p*PORT_W +: PORT_W]),
      .pin_o      (bidir_pins_o[p*PORT_W +: PORT_W]),
      .pin_oe_o   (bidir_pins_oe_o[p*PORT_W +: PORT_W]),
      .rdata_o    (port_rd[p*PORT_W +: PORT_W]),
      .dir_o      (dir_o[p*PORT_W +: PORT_W])
    );
  end

  // ****************************************************************
  // Fixed input port
  // ****************************************************************
  // Enables come from the serial units on this clock, not pins
  logic [PORT_W-1:0] fix_mask;
  logic [PORT_W-1:0] fix_rd;

  always_comb begin
    fix_mask = PIO_FIX_PRESENT;
    if (serial_en_i) begin
      fix_mask = fix_mask & ~PIO_SERIAL_MASK;        // [RULE_11] [RULE_13]
    end
    if (spi_en_i) begin
      fix_mask = fix_mask & ~PIO_SPI_MASK;           // [RULE_11] [RULE_14]
    end
  end
  assign fix_rd = fix_s2 & fix_mask;                 // [RULE_10] [RULE_12]

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [PORT_W-1:0] next_rdata;

  always_comb begin
    if (req_i.sel == PIO_SEL_FIX) begin
      next_rdata = req_i.dir ? '0 : fix_rd;          // Fixed port has no direction
    end else if (req_i.dir) begin
      next_rdata = dir_o[req_i.sel*PORT_W +: PORT_W];
    end else begin
      next_rdata = port_rd[req_i.sel*PORT_W +: PORT_W];  // [RULE_07] [RULE_08]
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o  <= '0;
      rvalid_o <= 1'b0;
    end else if (ce_i) begin
      rvalid_o <= bus_tick && req_i.rd;
      if (bus_tick && req_i.rd) begin
        rdata_o <= next_rdata;                       // [RULE_10]
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  bus_half_rate_a: assert property (ce_i && bus_tick |=> !bus_tick)  // [RULE_15]
    else $error("bus tick not at half rate");
  read_pulse_a: assert property (ce_i && rvalid_o |=> !rvalid_o)  // [RULE_15]
    else $error("read valid longer than one cycle");
  dir_output_drive_a: assert property (  // [RULE_06]
    ce_i && bus_tick && req_i.wr && !req_i.dir && req_i.sel == PIO_SEL_P1
    |=> bidir_pins_o[PORT_W-1:0] == ($past(req_i.wdata) & dir_o[PORT_W-1:0]))
    else $error("output pin differs from written data");
  input_undriven_a: assert property (!dir_o[0] |-> !bidir_pins_oe_o[0])  // [RULE_05]
    else $error("input pin driven");
  dir_write_a: assert property (  // [RULE_01]
    ce_i && bus_tick && req_i.wr && req_i.dir && req_i.sel == PIO_SEL_P1
    |=> dir_o[PORT_W-1:0] == $past(req_i.wdata))
    else $error("direction write lost");
  serial_zero_a: assert property (  // [RULE_11]
    ce_i && bus_tick && req_i.rd && req_i.sel == PIO_SEL_FIX && !req_i.dir && serial_en_i
    |=> rdata_o[PIO_LN_TXD:PIO_LN_RXD] == 2'h0)
    else $error("serial lines not zero");
  spi_zero_a: assert property (  // [RULE_11]
    ce_i && bus_tick && req_i.rd && req_i.sel == PIO_SEL_FIX && !req_i.dir && spi_en_i
    |=> rdata_o[PIO_LN_SS:PIO_LN_MISO] == 4'h0)
    else $error("spi lines not zero");
  fixed_level_a: assert property (  // [RULE_10]
    ce_i && bus_tick && req_i.rd && req_i.sel == PIO_SEL_FIX && !req_i.dir
    && !serial_en_i && !spi_en_i
    |=> rdata_o == $past(fix_s2 & PIO_FIX_PRESENT))
    else $error("fixed port read mismatch");
  // Output bits must follow the drive, input bits the synchronised pin
  read_latch_a: assert property (  // [RULE_08]
    ce_i && bus_tick && req_i.rd && req_i.sel == PIO_SEL_P1 && !req_i.dir
    |=> rdata_o == $past((bidir_pins_o[PORT_W-1:0] & dir_o[PORT_W-1:0])
                         | (bidir_s2[PORT_W-1:0] & ~dir_o[PORT_W-1:0])))
    else $error("port read mismatch");
  unused_line_a: assert property (  // [RULE_10]
    ce_i && bus_tick && req_i.rd && req_i.sel == PIO_SEL_FIX
    |=> rdata_o[PIO_LN_NONE] == 1'b0)
    else $error("missing line reads one");
  // A held-off cycle must not let a pending read or direction write slip through
  ce_freeze_a: assert property (  // [RULE_17]
    !ce_i |=> $stable(dir_o) && $stable(rdata_o) && $stable(rvalid_o) && $stable(bus_tick))
    else $error("state moved with clock enable low");

  write_cov: cover property (ce_i && bus_tick && req_i.wr && !req_i.dir);
  dir_cov: cover property (ce_i && bus_tick && req_i.wr && req_i.dir);
  fix_cov: cover property (rvalid_o && spi_en_i && serial_en_i);
  hold_cov: cover property (!ce_i && bus_tick && req_i.wr);

endmodule
`default_nettype wire

// ### pio_board.sv
/*
  Board-side model of the three bidirectional ports: resolves each pin from
  the block's drive and the board's own level.
  Assumes the board drives every pin that the block leaves as an input.
*/
`timescale 1ns/1ps
`default_nettype none
module pio_board (
  // Block side
  input  wire logic [23:0] pin_i,
  input  wire logic [23:0] oe_i,
  // Board side
  input  wire logic [23:0] drv_i,
  input  wire logic        load_i,
  output logic      [23:0] pins_o
);
  // ****************************************************************
  // Pin resolution
  // ****************************************************************
  // A heavy load pulls driven pins to the opposite level, so a read that
  // follows the pin instead of the latch shows up at once
  assign pins_o = (oe_i & (load_i ? ~pin_i : pin_i)) | (~oe_i & drv_i);
endmodule
`default_nettype wire

// ### pio_tb.sv
/*
  Self-checking bench for the parallel port block: bus requests, pin levels
  and the fixed input port with the serial units on and off.
  Assumes the pio_board model stands on the bidirectional pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pio_pkg::*;
  logic        mclk_i = 0, rst_i = 1, ce_i = 1, load = 0;
  logic        serial_en_i = 0, spi_en_i = 0, rvalid_o, bus_phase_o;
  pio_req_t    req_i = '0;
  logic [23:0] drv = 24'h5ac3a5, bpi, bpo, boe, dir_o;
  logic [7:0]  fix = 8'he7, rdata_o, rd, v;
  int          err_total = 0, n_tests = 0, p, hi;

  always #20 mclk_i = ~mclk_i;

  pio_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .bus_phase_o(bus_phase_o),
    .serial_en_i(serial_en_i), .spi_en_i(spi_en_i), .bidir_pins_i(bpi),
    .bidir_pins_o(bpo), .bidir_pins_oe_o(boe),
    .fixed_input_port_pins_i(fix), .dir_o(dir_o));

  pio_board board_u (.pin_i(bpo), .oe_i(boe), .drv_i(drv), .load_i(load),
    .pins_o(bpi));

  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ****************************************************************
  // Bus access: request held until a bus-phase edge takes it
  // ****************************************************************
  task automatic bus(input logic w, input logic d, input logic [1:0] s,
                     input logic [7:0] val, output logic [7:0] r);
    int  i;
    logic ok;
    ok = 0;
    r = 8'h00;
    @(negedge mclk_i);
    req_i = '{wr: w, rd: ~w, dir: d, sel: s, wdata: val};
    for (i = 0; i < 8 && !ok; i++) begin
      ok = (bus_phase_o === 1'b1);
      @(posedge mclk_i);
      if (!ok) @(negedge mclk_i);
    end
    @(negedge mclk_i);
    req_i = '0;
    if (!w) begin
      ok = 0;
      for (i = 0; i < 3 && !ok; i++) begin
        if (rvalid_o === 1'b1) begin
          ok = 1;
          r = rdata_o;
        end else @(negedge mclk_i);
      end
    end
    if (!ok) begin
      err_total++;
      $display("MISMATCH t=%0t bus request not answered", $time);
      summarize();
    end
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (16) @(negedge mclk_i);
    rst_i = 0;
    repeat (2) @(negedge mclk_i);
    chk(dir_o, 24'h000000);
    chk(boe, 24'h000000);
    bus(1'b0, 1'b0, PIO_SEL_FIX, 8'h00, rd);
    chk({16'h0000, rd}, 24'h0000a7);
    hi = 0;
    repeat (8) begin
      @(negedge mclk_i);
      hi += int'(bus_phase_o);
    end
    chk(24'(hi), 24'h000004);
    for (p = 0; p < 3; p++) begin
      v = 8'h96 + 8'(p * 33);
      // Latch first, so the pins never drive an unknown level
      bus(1'b1, 1'b0, 2'(p), v, rd);
      repeat (4) @(negedge mclk_i);
      chk({16'h0000, boe[p*8+:8]}, 24'h000000);
      bus(1'b0, 1'b0, 2'(p), 8'h00, rd);
      chk({16'h0000, rd}, {16'h0000, drv[p*8+:8]});
      bus(1'b1, 1'b1, 2'(p), 8'h0f, rd);
      chk({16'h0000, boe[p*8+:8]}, 24'h00000f);
      chk({16'h0000, bpo[p*8+:8] & 8'h0f}, {16'h0000, v & 8'h0f});
      load = 1;
      repeat (4) @(negedge mclk_i);
      bus(1'b0, 1'b0, 2'(p), 8'h00, rd);
      chk({16'h0000, rd}, {16'h0000, (v & 8'h0f) | (drv[p*8+:8] & 8'hf0)});
      load = 0;
    end
    chk(dir_o, 24'h0f0f0f);
    rst_i = 1;
    repeat (2) @(negedge mclk_i);
    chk(dir_o, 24'h000000);
    rst_i = 0;
    repeat (2) @(negedge mclk_i);
    for (p = 0; p < 3; p++) begin
      bus(1'b1, 1'b1, 2'(p), 8'hff, rd);
      chk({16'h0000, bpo[p*8+:8]}, {16'h0000, 8'h96 + 8'(p * 33)});
    end
    fix = 8'hff;
    for (p = 0; p < 4; p++) begin
      serial_en_i = p[0];
      spi_en_i = p[1];
      repeat (3) @(negedge mclk_i);
      bus(1'b0, 1'b0, PIO_SEL_FIX, 8'h00, rd);
      v = 8'hbf & ~(p[0] ? 8'h03 : 8'h00) & ~(p[1] ? 8'h3c : 8'h00);
      chk({16'h0000, rd}, {16'h0000, v});
    end
    // Freeze the divider on its acting phase, then offer a write that must not land
    @(negedge mclk_i);
    if (bus_phase_o !== 1'b1) @(negedge mclk_i);
    ce_i = 0;
    req_i = '{wr: 1'b1, rd: 1'b0, dir: 1'b1, sel: PIO_SEL_P1, wdata: 8'h00};
    repeat (4) @(negedge mclk_i);
    req_i = '0;
    ce_i = 1;
    chk(dir_o, 24'hffffff);
    chk(boe, 24'hffffff);
    summarize();
  end
endmodule
`default_nettype wire
